// ===== inc/ssp_defs.vh
/*
 * Constants for the serial slot placement block: register offsets, reset
 * values, field positions, width and sense codes, slot lengths.
 * Assumes it is included by bare name from the design files.
 */
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH

`define SSP_OFS_THREE 8'h08
`define SSP_OFS_FOUR 8'h09
`define SSP_OFS_FIVE 8'h0a

`define SSP_RST_THREE 8'h32
`define SSP_RST_FOUR 8'h07
`define SSP_RST_FIVE 8'h07

`define SSP_WID_HI 5
`define SSP_WID_LO 4
`define SSP_SNS_HI 2
`define SSP_SNS_LO 0

`define SSP_WID_24 2'h0
`define SSP_WID_16 2'h1

`define SSP_SNS_VOLT 3'h0
`define SSP_SNS_CURR 3'h1
`define SSP_SNS_BATT 3'h2
`define SSP_SNS_CTRL 3'h3
`define SSP_SNS_ALT 3'h4
`define SSP_SNS_STAT 3'h5
`define SSP_SNS_MARK 3'h6
`define SSP_SNS_BLANK 3'h7

`define SSP_BITS_24 5'h18
`define SSP_BITS_16 5'h10
`define SSP_BITS_8 5'h08
`define SSP_BITS_ONE 5'h01

`define SSP_ID_THREE 3'h3
`define SSP_ID_FOUR 3'h4
`define SSP_ID_FIVE 3'h5

`define SSP_FIFO_WIDTH 24
`define SSP_FIFO_DEPTH 4

`endif

// ===== hw/ssp_slot_cfg.v
/*
 * Slot placement configuration for placements three to five of a TDM/I2S
 * slave port: the three control registers, the audio input slot parser,
 * the sense output slot serialiser and a small sample FIFO.
 * Assumes serial bits arrive synchronous to CLK_SYS_IN, one per BIT_STB_IN,
 * MSB first, and that the frame logic outside pulses the slot starts.
 */
`include "ssp_defs.vh"

module ssp_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 4
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire in_valid_in,
  output reg in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output reg out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  // Head stays at index 0 so the output is a flop, not a read mux
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [3:0] count;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  wire [3:0] next_count = count + {3'h0, push} - {3'h0, pop};
  integer i;

  assign out_data_out = mem[0];

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count <= 4'h0;
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
    end else begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        if (pop && i < DEPTH - 1) begin
          mem[i] <= mem[i+1];
        end
        if (push && i == count - {3'h0, pop}) begin
          mem[i] <= in_data_in;
        end
      end
      count <= next_count;
      in_ready_out <= (next_count != DEPTH);
      out_valid_out <= (next_count != 4'h0);
    end
  end
endmodule

// Function
// - Placement three width: 24, 16, or discard 8
// - Placement three discard: drop 8, audio from four
// - Placement three sense code picks driven item
// - Placement three register resets to 0x32
// - Placement four width same codes, resets 24-bit
// - Placement four sense same codes, resets blank
// - Placement five sense only, upper reserved, blank
// - Placement two discard: audio from placement three
module ssp_slot_cfg (
  input wire CLK_SYS_IN,
  input wire ARST_N_IN,
  input wire REG_WR_IN,
  input wire REG_RD_IN,
  input wire [7:0] REG_ADDR_IN,
  input wire [7:0] REG_WDATA_IN,
  output reg [7:0] REG_RDATA_OUT,
  input wire [1:0] PLACE_TWO_INPUT_WIDTH_IN,
  input wire BIT_STB_IN,
  input wire SDI_IN,
  input wire RX_START_IN,
  input wire TX_START_IN,
  input wire [15:0] VOLT_IN,
  input wire [15:0] CURR_IN,
  input wire [7:0] BATT_IN,
  input wire [7:0] CTRL_IN,
  input wire [7:0] STAT_IN,
  output reg SDO_OUT,
  output reg SDO_OE_OUT,
  output reg RX_BUSY_OUT,
  output reg OVERRUN_OUT,
  output wire SAMPLE_VALID_OUT,
  input wire SAMPLE_READY_IN,
  output wire [23:0] SAMPLE_DATA_OUT,
  output wire SAMPLE_ROOM_OUT
);
  localparam RX_IDLE = 4'h1;
  localparam RX_TWO = 4'h2;
  localparam RX_THREE = 4'h4;
  localparam RX_FOUR = 4'h8;
  localparam TX_IDLE = 4'h1;
  localparam TX_THREE = 4'h2;
  localparam TX_FOUR = 4'h4;
  localparam TX_FIVE = 4'h8;
  // Named so the reset branch can slice fields out of the documented bytes
  localparam [7:0] RST_THREE = `SSP_RST_THREE;
  localparam [7:0] RST_FOUR = `SSP_RST_FOUR;
  localparam [7:0] RST_FIVE = `SSP_RST_FIVE;

  // Only the fields are stored, so reserved bits cannot steer anything
  reg [1:0] place_three_input_width;
  reg [2:0] place_three_sense_select;
  reg [1:0] place_four_input_width;
  reg [2:0] place_four_sense_select;
  reg [2:0] place_five_sense_select;

  reg [3:0] rx_state;
  reg [4:0] rx_cnt;
  reg [23:0] rx_sh;
  reg push_valid;
  reg [23:0] push_data;
  reg [3:0] tx_state;
  reg [4:0] tx_cnt;
  reg [15:0] tx_sh;
  reg tx_blank;
  reg alt_curr;
  wire fifo_ready;

  function [4:0] in_bits;
    input [1:0] code;
    begin
      case (code)
        `SSP_WID_24: in_bits = `SSP_BITS_24;
        `SSP_WID_16: in_bits = `SSP_BITS_16;
        default: in_bits = `SSP_BITS_8;
      endcase
    end
  endfunction

  function is_discard;
    input [1:0] code;
    begin
      is_discard = (code != `SSP_WID_24) && (code != `SSP_WID_16);
    end
  endfunction

  function [4:0] sns_bits;
    input [2:0] code;
    begin
      case (code)
        `SSP_SNS_VOLT, `SSP_SNS_CURR, `SSP_SNS_ALT: sns_bits = `SSP_BITS_16;
        default: sns_bits = `SSP_BITS_8;
      endcase
    end
  endfunction

  // Item left-justified in 16 bits; 8-bit items use the upper byte
  function [15:0] sns_word;
    input [2:0] code;
    input [2:0] slot_id;
    input alt;
    begin
      case (code)
        `SSP_SNS_VOLT: sns_word = VOLT_IN;
        `SSP_SNS_CURR: sns_word = CURR_IN;
        `SSP_SNS_BATT: sns_word = {BATT_IN, 8'h00};
        `SSP_SNS_CTRL: sns_word = {CTRL_IN, 8'h00};
        `SSP_SNS_ALT: sns_word = alt ? CURR_IN : VOLT_IN;
        `SSP_SNS_STAT: sns_word = {STAT_IN, 8'h00};
        `SSP_SNS_MARK: sns_word = {alt, 4'h0, slot_id, 8'h00};
        default: sns_word = 16'h0000;
      endcase
    end
  endfunction

  always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      place_three_input_width <= RST_THREE[`SSP_WID_HI:`SSP_WID_LO];
      place_three_sense_select <= RST_THREE[`SSP_SNS_HI:`SSP_SNS_LO];
      place_four_input_width <= RST_FOUR[`SSP_WID_HI:`SSP_WID_LO];
      place_four_sense_select <= RST_FOUR[`SSP_SNS_HI:`SSP_SNS_LO];
      place_five_sense_select <= RST_FIVE[`SSP_SNS_HI:`SSP_SNS_LO];
      REG_RDATA_OUT <= 8'h00;
    end else begin
      if (REG_WR_IN) begin
        case (REG_ADDR_IN)
          `SSP_OFS_THREE: begin
            place_three_input_width <= REG_WDATA_IN[`SSP_WID_HI:`SSP_WID_LO];
            place_three_sense_select <= REG_WDATA_IN[`SSP_SNS_HI:`SSP_SNS_LO];
          end
          `SSP_OFS_FOUR: begin
            place_four_input_width <= REG_WDATA_IN[`SSP_WID_HI:`SSP_WID_LO];
            place_four_sense_select <= REG_WDATA_IN[`SSP_SNS_HI:`SSP_SNS_LO];
          end
          `SSP_OFS_FIVE: begin
            place_five_sense_select <= REG_WDATA_IN[`SSP_SNS_HI:`SSP_SNS_LO];
          end
          default: begin
          end
        endcase
      end
      if (REG_RD_IN) begin
        case (REG_ADDR_IN)
          `SSP_OFS_THREE: REG_RDATA_OUT <=
            {2'h0, place_three_input_width, 1'b0, place_three_sense_select};
          `SSP_OFS_FOUR: REG_RDATA_OUT <=
            {2'h0, place_four_input_width, 1'b0, place_four_sense_select};
          `SSP_OFS_FIVE: REG_RDATA_OUT <= {5'h00, place_five_sense_select};
          default: REG_RDATA_OUT <= 8'h00;
        endcase
      end
    end
  end

  // Audio slot parser: discarding placements two and three hand the sample to the next one
  always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rx_state <= RX_IDLE;
      rx_cnt <= 5'h00;
      rx_sh <= 24'h000000;
      push_valid <= 1'b0;
      push_data <= 24'h000000;
      RX_BUSY_OUT <= 1'b0;
      OVERRUN_OUT <= 1'b0;
    end else begin
      OVERRUN_OUT <= 1'b0;
      // The serial bus cannot be stalled, so a full FIFO loses the sample
      if (push_valid) begin
        push_valid <= 1'b0;
        OVERRUN_OUT <= !fifo_ready;
      end
      if (RX_START_IN) begin
        rx_state <= RX_TWO;
        rx_cnt <= in_bits(PLACE_TWO_INPUT_WIDTH_IN);
        RX_BUSY_OUT <= 1'b1;
      end else if (BIT_STB_IN && !rx_state[0]) begin
        rx_sh <= {rx_sh[22:0], SDI_IN};
        rx_cnt <= rx_cnt - `SSP_BITS_ONE;
        if (rx_cnt == `SSP_BITS_ONE) begin
          case (rx_state)
            RX_TWO: begin
              if (is_discard(PLACE_TWO_INPUT_WIDTH_IN)) begin
                rx_state <= RX_THREE;
                rx_cnt <= in_bits(place_three_input_width);
              end else begin
                rx_state <= RX_IDLE;
                push_valid <= 1'b1;
              end
            end
            RX_THREE: begin
              if (is_discard(place_three_input_width)) begin
                rx_state <= RX_FOUR;
                rx_cnt <= in_bits(place_four_input_width);
              end else begin
                rx_state <= RX_IDLE;
                push_valid <= 1'b1;
              end
            end
            RX_FOUR: begin
              rx_state <= RX_IDLE;
              push_valid <= !is_discard(place_four_input_width);
            end
            default: rx_state <= RX_IDLE;
          endcase
          RX_BUSY_OUT <= (rx_state != RX_FOUR) &&
            is_discard(rx_state[1] ? PLACE_TWO_INPUT_WIDTH_IN : place_three_input_width);
          // 16-bit words are left-justified into the 24-bit sample
          if (rx_cnt == `SSP_BITS_ONE && in_bits(rx_state[1] ? PLACE_TWO_INPUT_WIDTH_IN :
              rx_state[2] ? place_three_input_width : place_four_input_width)
              == `SSP_BITS_16) begin
            push_data <= {rx_sh[14:0], SDI_IN, 8'h00};
          end else begin
            push_data <= {rx_sh[22:0], SDI_IN};
          end
        end
      end
    end
  end

  // Sense serialiser: placements three, four and five in turn
  always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      tx_state <= TX_IDLE;
      tx_cnt <= 5'h00;
      tx_sh <= 16'h0000;
      tx_blank <= 1'b1;
      alt_curr <= 1'b1;
      SDO_OUT <= 1'b0;
      SDO_OE_OUT <= 1'b0;
    end else begin
      if (TX_START_IN) begin
        tx_state <= TX_THREE;
        alt_curr <= !alt_curr;
        tx_cnt <= sns_bits(place_three_sense_select);
        tx_sh <= sns_word(place_three_sense_select, `SSP_ID_THREE, !alt_curr);
        tx_blank <= (place_three_sense_select == `SSP_SNS_BLANK);
      end else if (BIT_STB_IN && !tx_state[0]) begin
        SDO_OUT <= tx_sh[15];
        SDO_OE_OUT <= !tx_blank;
        tx_sh <= {tx_sh[14:0], 1'b0};
        tx_cnt <= tx_cnt - `SSP_BITS_ONE;
        if (tx_cnt == `SSP_BITS_ONE) begin
          case (tx_state)
            TX_THREE: begin
              tx_state <= TX_FOUR;
              tx_cnt <= sns_bits(place_four_sense_select);
              tx_sh <= sns_word(place_four_sense_select, `SSP_ID_FOUR, alt_curr);
              tx_blank <= (place_four_sense_select == `SSP_SNS_BLANK);
            end
            TX_FOUR: begin
              tx_state <= TX_FIVE;
              tx_cnt <= sns_bits(place_five_sense_select);
              tx_sh <= sns_word(place_five_sense_select, `SSP_ID_FIVE, alt_curr);
              tx_blank <= (place_five_sense_select == `SSP_SNS_BLANK);
            end
            default: begin
              tx_state <= TX_IDLE;
              tx_blank <= 1'b1;
            end
          endcase
        end
      end else if (BIT_STB_IN) begin
        SDO_OUT <= 1'b0;
        SDO_OE_OUT <= 1'b0;
      end
    end
  end

  ssp_fifo #(
    .WIDTH(`SSP_FIFO_WIDTH),
    .DEPTH(`SSP_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(CLK_SYS_IN),
    .arst_n_in(ARST_N_IN),
    .in_valid_in(push_valid),
    .in_ready_out(fifo_ready),
    .in_data_in(push_data),
    .out_valid_out(SAMPLE_VALID_OUT),
    .out_ready_in(SAMPLE_READY_IN),
    .out_data_out(SAMPLE_DATA_OUT)
  );

  assign SAMPLE_ROOM_OUT = fifo_ready;
endmodule

// ===== dv/ssp_chk.sv
/* Port checker for ssp_slot_cfg.
   Assumes it is bound to the block and sees only its ports. */
module ssp_chk (
  input wire CLK_SYS_IN,
  input wire ARST_N_IN,
  input wire REG_RD_IN,
  input wire [7:0] REG_ADDR_IN,
  input wire [7:0] REG_RDATA_OUT,
  input wire BIT_STB_IN,
  input wire RX_START_IN,
  input wire SDO_OUT,
  input wire SDO_OE_OUT,
  input wire RX_BUSY_OUT,
  input wire OVERRUN_OUT,
  input wire SAMPLE_VALID_OUT,
  input wire SAMPLE_READY_IN,
  input wire [23:0] SAMPLE_DATA_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!ARST_N_IN);
  five_rsv_a: assert property (REG_RD_IN && REG_ADDR_IN == 8'h0a |=>
    REG_RDATA_OUT[7:3] == 5'h00) else $error("place five reserved set");
  rsv_zero_a: assert property (REG_RD_IN && REG_ADDR_IN inside {8'h08, 8'h09} |=>
    (REG_RDATA_OUT & 8'hc8) == 8'h00) else $error("reserved bits set");
  unmapped_read_a: assert property (REG_RD_IN &&
    !(REG_ADDR_IN inside {8'h08, 8'h09, 8'h0a}) |=> REG_RDATA_OUT == 8'h00)
    else $error("unmapped read nonzero");
  rd_hold_a: assert property (!REG_RD_IN ##1 !REG_RD_IN |=>
    $stable(REG_RDATA_OUT)) else $error("read data moved");
  sdo_hold_a: assert property (!BIT_STB_IN |=>
    $stable(SDO_OUT) && $stable(SDO_OE_OUT)) else $error("sense moved without strobe");
  ovr_pulse_a: assert property (OVERRUN_OUT |=> !OVERRUN_OUT)
    else $error("overrun too long");
  valid_hold_a: assert property (SAMPLE_VALID_OUT && !SAMPLE_READY_IN |=>
    SAMPLE_VALID_OUT && $stable(SAMPLE_DATA_OUT)) else $error("sample lost");
  busy_start_a: assert property (RX_START_IN |=> RX_BUSY_OUT)
    else $error("parser not busy");
  cover property (OVERRUN_OUT);
  cover property (SAMPLE_VALID_OUT && SAMPLE_READY_IN);
  cover property ($rose(SDO_OE_OUT));
endmodule
bind ssp_slot_cfg ssp_chk u_ssp_chk (.*);

// ===== dv/ssp_master.sv
/* Serial bus master model: frame starts, bit strobes, input bits, and
   capture of returned sense bits. Assumes the block's clock. */
module ssp_master (
  input wire logic clk_in,
  input wire logic sdo_in,
  input wire logic sdo_oe_in,
  output logic bit_stb_out = 1'b0,
  output logic sdi_out = 1'b0,
  output logic rx_start_out = 1'b0,
  output logic tx_start_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic stb_q = 1'b0;
  logic [47:0] cap = '0, oec = '0;
  always @(posedge clk_in) begin
    stb_q <= bit_stb_out;
    if (stb_q) begin
      cap <= {cap[46:0], sdo_in};
      oec <= {oec[46:0], sdo_oe_in};
    end
  end
  // Stalled bits show the inverse so stale data can never pass
  task automatic send(input logic [47:0] f, input int n, input bit rx, input int gap);
    @(posedge clk_in);
    rx_start_out <= rx;
    tx_start_out <= !rx;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk_in);
      rx_start_out <= 1'b0;
      tx_start_out <= 1'b0;
      bit_stb_out <= 1'b1;
      sdi_out <= f[i];
      repeat (gap) begin
        @(posedge clk_in);
        bit_stb_out <= 1'b0;
        sdi_out <= !f[i];
      end
    end
    @(posedge clk_in);
    bit_stb_out <= 1'b0;
    sdi_out <= !sdi_out;
  endtask
endmodule

// ===== dv/testbench.sv
/* Bench for ssp_slot_cfg: registers, audio slot parsing, FIFO, sense slots.
   Assumes ssp_master on the serial side and ssp_chk bound. */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, rdy = 0, ovr_seen = 0;
  logic [7:0] addr = 0, wdat = 0, rdat, batt = 8'hb4, ctl = 8'h2d, stat = 8'h71;
  logic [1:0] p2w = 2'h2, e;
  logic [11:0] cfg;
  logic [15:0] volt = 16'h9c3a, curr = 16'h61e5, v;
  logic [23:0] sdat, d;
  logic [31:0] ev, eo, mk;
  logic sdo, oe, busy, ovr, sval, room;
  wire stb, sdi, rxs, txs;
  int n_errors = 0, total_checks = 0, tx_n = 0, k, dw, l;
  // Per frame: [9:8] placement two, [5:4] placement three, [1:0] placement four width
  localparam logic [83:0] AUD = {12'h222, 12'h331, 12'h220, 12'h200, 12'h210, 12'h131,
    12'h000};
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
  ssp_slot_cfg u_ssp_slot_cfg (.CLK_SYS_IN(clk), .ARST_N_IN(rst_n), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdat), .REG_RDATA_OUT(rdat),
    .PLACE_TWO_INPUT_WIDTH_IN(p2w), .BIT_STB_IN(stb), .SDI_IN(sdi), .RX_START_IN(rxs),
    .TX_START_IN(txs), .VOLT_IN(volt), .CURR_IN(curr), .BATT_IN(batt), .CTRL_IN(ctl),
    .STAT_IN(stat), .SDO_OUT(sdo), .SDO_OE_OUT(oe), .RX_BUSY_OUT(busy), .OVERRUN_OUT(ovr),
    .SAMPLE_VALID_OUT(sval), .SAMPLE_READY_IN(rdy), .SAMPLE_DATA_OUT(sdat),
    .SAMPLE_ROOM_OUT(room));
  ssp_master u_ssp_master (.clk_in(clk), .sdo_in(sdo), .sdo_oe_in(oe), .bit_stb_out(stb),
    .sdi_out(sdi), .rx_start_out(rxs), .tx_start_out(txs));
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (ovr === 1'b1) ovr_seen <= 1'b1;
  task automatic test_done();
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdat <= x;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    `CHK(rdat, x)
  endtask
  task automatic pop(input logic [23:0] x);
    k = 0;
    do begin
      @(negedge clk);
      k++;
      if (k > 300) begin
        n_errors++;
        $display("[FAIL] %0t sample timeout", $time);
        test_done();
      end
    end while (sval !== 1'b1);
    `CHK(sdat, x)
    @(posedge clk);
    rdy <= 1'b1;
    @(posedge clk);
    rdy <= 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h08, 8'h32);
    rchk(8'h09, 8'h07);
    rchk(8'h0a, 8'h07);
    wreg(8'h0b, 8'h55);
    rchk(8'h0b, 8'h00);
    wreg(8'h0a, 8'hfd);
    rchk(8'h0a, 8'h05);
    wreg(8'h09, 8'hff);
    rchk(8'h09, 8'h37);
    for (int i = 0; i < 7; i++) begin
      cfg = AUD[12 * i +: 12];
      wreg(8'h08, {2'h0, cfg[5:4], 4'h7});
      p2w <= cfg[9:8];
      wreg(8'h09, {2'h0, cfg[1:0], 4'h7});
      e = !cfg[9] ? cfg[9:8] : cfg[5] ? cfg[1:0] : cfg[5:4];
      dw = e[0] ? 16 : 24;
      d = 24'hd34b9e + 24'(i);
      u_ssp_master.send({24'hf05a3c, d} >> (24 - dw), 8 * cfg[9] + 8 * (cfg[9] & cfg[5]) + dw,
        1'b1, i % 2);
      if (e[1]) begin
        repeat (40) @(posedge clk);
        `CHK(sval, 1'b0)
        `CHK(busy, 1'b0)
      end else
        pop(dw == 24 ? d : {d[23:8], 8'h00});
    end
    wreg(8'h08, 8'h17);
    for (int j = 0; j < 5; j++)
      u_ssp_master.send({24'h0, 8'h5a, 16'h4a10 + 16'(j)}, 24, 1'b1, j % 2);
    repeat (4) @(negedge clk);
    `CHK(ovr_seen, 1'b1)
    `CHK(room, 1'b0)
    for (int j = 0; j < 4; j++)
      pop({16'h4a10 + 16'(j), 8'h00});
    @(negedge clk);
    `CHK(sval, 1'b0)
    wreg(8'h09, 8'h07);
    wreg(8'h0a, 8'h07);
    for (int c = 0; c < 9; c++) begin
      if (c < 8)
        wreg(8'h08, {5'h00, 3'(c)});
      else
        wreg(8'h0a, 8'h05);
      case (c)
        0: v = volt;
        1: v = curr;
        2: v = 16'(batt);
        3: v = 16'(ctl);
        4: v = tx_n[0] ? curr : volt;
        5, 8: v = 16'(stat);
        6: v = {8'h00, tx_n[0], 7'h03};
        default: v = 16'h0000;
      endcase
      l = (c == 0 || c == 1 || c == 4) ? 16 : 8;
      ev = 32'(v) << (32 - l - (c / 8) * 16);
      eo = c == 7 ? 32'h0 : ((32'h1 << l) - 1) << (32 - l - (c / 8) * 16);
      mk = l == 16 ? 32'hffffffff : 32'hffffff00;
      u_ssp_master.send(48'h0, 32, 1'b0, 0);
      tx_n++;
      repeat (3) @(posedge clk);
      `CHK(u_ssp_master.cap[31:0] & mk, ev)
      `CHK(u_ssp_master.oec[31:0], eo)
    end
    // Reset in mid-run must bring every placement back to its default
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h08, 8'h32);
    rchk(8'h09, 8'h07);
    rchk(8'h0a, 8'h07);
    test_done();
  end
endmodule
